// ### acc_pkg.sv
// Package for the analog comparator control block.
// Assumes an 8-bit register port with data-space and I/O-space addresses.
package acc_pkg;
    // ========================================
    // Register addresses
    localparam logic [7:0] ACC_CSR_ADDR = 8'h50;
    localparam logic [7:0] ACC_IO_OFFSET = 8'h20;
    localparam logic [7:0] ACC_CSR_IO_ADDR = 8'h30;
    localparam logic [7:0] ACC_CTRLB_ADDR = 8'h7B;
    // ========================================
    // Control/status register fields
    localparam int ACC_POWER_OFF_BIT = 7;
    localparam int ACC_BANDGAP_BIT = 6;
    localparam int ACC_RESULT_BIT = 5;
    localparam int ACC_FLAG_BIT = 4;
    localparam int ACC_IRQ_EN_BIT = 3;
    localparam int ACC_CAPTURE_BIT = 2;
    localparam int ACC_MODE_HI_BIT = 1;
    localparam int ACC_MODE_LO_BIT = 0;
    localparam logic [7:0] ACC_CSR_RESET = 8'h00;
    // ========================================
    // Converter control B fields
    localparam int ACC_MUX_EN_BIT = 6;
    localparam int ACC_TRIG_HI_BIT = 2;
    localparam logic [7:0] ACC_CTRLB_RESET = 8'h00;
    localparam logic [7:0] ACC_CTRLB_MASK = 8'h47;
    // ========================================
    // Enumerations
    typedef enum logic [1:0]
    {
        ACC_MODE_TOGGLE = 2'h0,
        ACC_MODE_RESERVED = 2'h1,
        ACC_MODE_FALL = 2'h2,
        ACC_MODE_RISE = 2'h3
    } acc_mode_t;
    typedef enum logic [2:0]
    {
        ACC_TRIG_FREE = 3'h0,
        ACC_TRIG_COMP = 3'h1,
        ACC_TRIG_EXT0 = 3'h2,
        ACC_TRIG_T0CA = 3'h3,
        ACC_TRIG_T0OV = 3'h4,
        ACC_TRIG_T1CB = 3'h5,
        ACC_TRIG_T1OV = 3'h6,
        ACC_TRIG_T1CAP = 3'h7
    } acc_trig_t;
endpackage

// ### acc_sync.sv
// Two-stage synchroniser for a level from outside the clock domain.
// Assumes a single clock and synchronous active-high reset.
module acc_sync
    import acc_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            meta_q <= '0;
            o_sync <= '0;
        end
        else
        begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule // acc_sync

// ### acc_comparator_control.sv
// Digital control around an on-chip voltage comparator and trigger select.
// Assumes the analog comparator and mux sit outside; raw result arrives
// asynchronously, event flags on this clock, register port is a simple 8-bit strobe bus.
//
// Behaviour
// - Result high when positive exceeds negative
// - Mux enabled, converter off: channel selects negative
// - Otherwise negative pin feeds negative input
// - Trigger field acts only with auto-trigger
// - Rising edge of selected flag starts conversion
// - Switching to free running gives no trigger
// - Trigger source encoding per field value
// - Power-off bit in bit 7 disables comparator
// - Bandgap select replaces positive pin
// - Result synchronised, one to two cycles
// - Flag set on event chosen by mode
// - Flag cleared by vector or writing one
// - Request needs local and global enable
// - Synchronised result routed to timer capture
// - Control register at 0x50 and I/O 0x30
// - Mode: toggle, reserved, falling, rising
// - Bit 2 enables capture connection
module acc_comparator_control
    import acc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic [7:0] i_addr,
    input wire logic i_io_space,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    input wire logic i_compare_raw,
    input wire logic i_converter_enable,
    input wire logic i_converter_auto_trigger_enable,
    input wire logic [2:0] i_channel_select_low,
    input wire logic i_global_irq_enable,
    input wire logic i_irq_vector_taken,
    input wire logic [7:0] i_trigger_flags,
    output logic o_comparator_power_off,
    output logic o_bandgap_positive_select,
    output logic o_negative_from_mux,
    output logic [2:0] o_negative_channel,
    output logic o_irq,
    output logic o_capture_trigger,
    output logic o_conversion_start
);
    // ========================================
    // Register decode
    logic [7:0] csr_q;
    logic [7:0] csr_d;
    logic [7:0] ctrlb_q;
    logic flag_q;
    logic result_sync;
    logic prev_q;
    logic trig_prev_q;
    logic [2:0] arm_q;

    // Both address spaces reach the control register
    wire logic csr_data_hit = !i_io_space && (i_addr == ACC_CSR_ADDR);
    wire logic csr_io_hit = i_io_space && (i_addr == ACC_CSR_IO_ADDR);
    wire logic csr_hit = csr_data_hit || csr_io_hit;
    wire logic ctrlb_hit = !i_io_space && (i_addr == ACC_CTRLB_ADDR);
    wire logic csr_wr = i_wr && csr_hit;
    wire logic ctrlb_wr = i_wr && ctrlb_hit;

    wire logic power_off = csr_q[ACC_POWER_OFF_BIT];
    wire acc_mode_t mode = acc_mode_t'(csr_q[ACC_MODE_HI_BIT:0]);
    wire logic mux_en = ctrlb_q[ACC_MUX_EN_BIT];
    wire acc_trig_t trig_sel = acc_trig_t'(ctrlb_q[ACC_TRIG_HI_BIT:0]);

    // ========================================
    // Result synchroniser, result only valid while powered
    acc_sync #(
        .WIDTH(1)
    ) u_result_sync (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_async(i_compare_raw),
        .o_sync(result_sync)
    );

    // Trigger flags come from other logic on this clock: no synchroniser
    // ========================================
    // Edge detection; sample frozen while powered off
    wire logic rise = result_sync && !prev_q;
    wire logic fall = !result_sync && prev_q;
    wire logic edge_live = !power_off;
    // Sync stages and sample start at zero; no events until they hold data
    wire logic armed = arm_q[2];
    logic event_hit;

    always_comb
    begin
        event_hit = 1'b0;
        unique case (mode)
            ACC_MODE_TOGGLE: event_hit = rise || fall;
            ACC_MODE_RESERVED: event_hit = 1'b0;
            ACC_MODE_FALL: event_hit = fall;
            ACC_MODE_RISE: event_hit = rise;
        endcase
    end

    wire logic flag_set = edge_live && armed && event_hit;
    // Set wins over either clear path
    wire logic flag_clr = i_irq_vector_taken
        || (csr_wr && i_wdata[ACC_FLAG_BIT]);
    wire logic flag_d = flag_set || (flag_q && !flag_clr);

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            prev_q <= 1'b0;
            flag_q <= 1'b0;
        end
        else
        begin
            if (edge_live)
                prev_q <= result_sync;
            flag_q <= flag_d;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            arm_q <= 3'h0;
        end
        else
        begin
            arm_q <= {arm_q[1:0], 1'b1};
        end
    end

    // ========================================
    // Register writes; flag and result bits are not stored here
    always_comb
    begin
        csr_d = csr_q;
        if (csr_wr)
        begin
            csr_d = i_wdata;
        end
        csr_d[ACC_RESULT_BIT] = 1'b0;
        csr_d[ACC_FLAG_BIT] = 1'b0;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            csr_q <= ACC_CSR_RESET;
        end
        else
        begin
            csr_q <= csr_d;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            ctrlb_q <= ACC_CTRLB_RESET;
        end
        else if (ctrlb_wr)
        begin
            ctrlb_q <= i_wdata & ACC_CTRLB_MASK;
        end
    end

    // ========================================
    // Read data, registered
    logic [7:0] csr_view;

    always_comb
    begin
        csr_view = csr_q;
        csr_view[ACC_RESULT_BIT] = result_sync;
        csr_view[ACC_FLAG_BIT] = flag_q;
    end

    wire logic [7:0] rdata_d = !i_rd ? 8'h00
        : csr_hit ? csr_view
        : ctrlb_hit ? ctrlb_q
        : 8'h00;

    // ========================================
    // Auto-trigger selection
    wire logic sel_flag = trig_sel == ACC_TRIG_COMP ? flag_d
        : i_trigger_flags[trig_sel];
    // Free running has no edge source, so switching to it fires nothing
    wire logic trig_level = (trig_sel != ACC_TRIG_FREE) && sel_flag;
    // Selection switch onto a set flag looks like an edge
    wire logic trig_edge = trig_level && !trig_prev_q;
    wire logic start_d = i_converter_auto_trigger_enable
        && i_converter_enable && trig_edge;

    // ========================================
    // Negative input selection, interrupt request and capture
    wire logic neg_mux_d = mux_en && !i_converter_enable;
    wire logic [2:0] neg_chan_d = neg_mux_d ? i_channel_select_low : 3'h0;
    wire logic irq_d = flag_d && csr_d[ACC_IRQ_EN_BIT]
        && i_global_irq_enable;
    wire logic capture_d = csr_d[ACC_CAPTURE_BIT]
        && result_sync && edge_live;

    // ========================================
    // Registered outputs, one short process each
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            o_rdata <= 8'h00;
        end
        else
        begin
            o_rdata <= rdata_d;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            trig_prev_q <= 1'b0;
        end
        else
        begin
            trig_prev_q <= trig_level;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            o_conversion_start <= 1'b0;
        end
        else
        begin
            o_conversion_start <= start_d;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            o_negative_from_mux <= 1'b0;
        end
        else
        begin
            o_negative_from_mux <= neg_mux_d;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            o_negative_channel <= 3'h0;
        end
        else
        begin
            o_negative_channel <= neg_chan_d;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            o_irq <= 1'b0;
        end
        else
        begin
            o_irq <= irq_d;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            o_capture_trigger <= 1'b0;
        end
        else
        begin
            o_capture_trigger <= capture_d;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            o_comparator_power_off <= 1'b0;
        end
        else
        begin
            o_comparator_power_off <= csr_d[ACC_POWER_OFF_BIT];
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            o_bandgap_positive_select <= 1'b0;
        end
        else
        begin
            o_bandgap_positive_select <= csr_d[ACC_BANDGAP_BIT];
        end
    end
endmodule // acc_comparator_control

// ### acc_cc_properties.sv
// Checker for the comparator control block, bound to its ports.
// Assumes one clock and a synchronous active-high reset.
module acc_cc_props
    import acc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic [7:0] i_addr,
    input wire logic i_io_space,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic i_converter_enable,
    input wire logic i_converter_auto_trigger_enable,
    input wire logic [2:0] i_channel_select_low,
    input wire logic i_global_irq_enable,
    input wire logic o_comparator_power_off,
    input wire logic o_bandgap_positive_select,
    input wire logic o_negative_from_mux,
    input wire logic [2:0] o_negative_channel,
    input wire logic o_irq,
    input wire logic o_capture_trigger,
    input wire logic o_conversion_start
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_srst);
    // ========
    // Sequences
    sequence s_csr_wr;
        i_wr && (i_io_space ? i_addr == ACC_CSR_IO_ADDR
            : i_addr == ACC_CSR_ADDR);
    endsequence
    sequence s_no_wr;
        !i_wr;
    endsequence
    // ========
    // Properties
    a_neg_chan: assert property (o_negative_from_mux |->
        o_negative_channel == $past(i_channel_select_low))
        else $error("negative channel differs from select");
    a_neg_pin: assert property ($past(i_converter_enable) |->
        !o_negative_from_mux && o_negative_channel == 3'h0)
        else $error("mux used while converter enabled");
    a_start_pulse: assert property (o_conversion_start |=>
        !o_conversion_start)
        else $error("start longer than one cycle");
    a_start_auto: assert property (o_conversion_start |->
        $past(i_converter_auto_trigger_enable))
        else $error("start without auto trigger");
    a_irq_global: assert property (o_irq |->
        $past(i_global_irq_enable))
        else $error("request without global enable");
    a_cap_off: assert property (
        o_comparator_power_off && $past(o_comparator_power_off)
        |-> !o_capture_trigger)
        else $error("capture while powered off");
    a_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data without read");
    a_csr_write: assert property (s_csr_wr ##1 s_no_wr |=>
        {o_comparator_power_off, o_bandgap_positive_select}
        == $past(i_wdata[7:6], 2))
        else $error("control bits not taken");
endmodule // acc_cc_props
bind acc_comparator_control acc_cc_props u_props (.i_clock, .i_srst,
    .i_addr, .i_io_space, .i_wr, .i_rd, .i_wdata, .o_rdata,
    .i_converter_enable, .i_converter_auto_trigger_enable,
    .i_channel_select_low, .i_global_irq_enable, .o_comparator_power_off,
    .o_bandgap_positive_select, .o_negative_from_mux, .o_negative_channel,
    .o_irq, .o_capture_trigger, .o_conversion_start);

// ### acc_analog_model.sv
// Behavioural analog side: input pins, channel mux and comparator.
// Assumes levels are unsigned codes driven by the bench.
module acc_analog_model
    import acc_pkg::*;
#(
    parameter logic [7:0] BANDGAP_LEVEL = 8'h80
)
(
    input wire logic i_clock,
    input wire logic [7:0] i_pos_pin,
    input wire logic [7:0] i_neg_pin,
    input wire logic [63:0] i_channels,
    input wire logic i_bandgap,
    input wire logic i_neg_mux,
    input wire logic [2:0] i_chan,
    input wire logic i_off,
    output logic o_raw
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] pos_lvl;
    logic [7:0] neg_lvl;
    assign pos_lvl = i_bandgap ? BANDGAP_LEVEL : i_pos_pin;
    assign neg_lvl = i_neg_mux ? i_channels[i_chan*8 +: 8] : i_neg_pin;
    initial o_raw = 1'b0;
    // Unpowered output churns, so frozen edge logic is really exercised
    always @(negedge i_clock) o_raw <= i_off ? ~o_raw : pos_lvl > neg_lvl;
endmodule // acc_analog_model

// ### tb_acc_comparator_control.sv
// Self-checking bench for the comparator control block.
// Assumes the analog model closes the loop from the mux outputs.
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("BAD %0t value mismatch", $time); end end
module tb_acc_comparator_control
    import acc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clock = 1'b0, i_srst = 1'b1, i_io_space = 1'b0, i_wr = 1'b0;
    logic i_rd = 1'b0, conv_en = 1'b0, auto_en = 1'b0, gie = 1'b0;
    logic vec = 1'b0, rd_seen = 1'b0, raw, off, bg, from_mux, irq, cap, st, f;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, flags = 8'h00, pos = 8'h00;
    logic [7:0] o_rdata, exp_q[$];
    logic [2:0] chsel = 3'h0, o_negative_channel;
    logic [63:0] chans;
    int n_fail = 0, n_checks = 0, seed = 32'h911C3476, n;
    initial forever #50 i_clock = ~i_clock;
    acc_comparator_control dut (.i_clock, .i_srst, .i_addr, .i_io_space,
        .i_wr, .i_rd, .i_wdata, .o_rdata, .i_compare_raw(raw),
        .i_converter_enable(conv_en), .i_converter_auto_trigger_enable(auto_en),
        .i_channel_select_low(chsel), .i_global_irq_enable(gie),
        .i_irq_vector_taken(vec), .i_trigger_flags(flags),
        .o_comparator_power_off(off), .o_bandgap_positive_select(bg),
        .o_negative_from_mux(from_mux), .o_negative_channel, .o_irq(irq),
        .o_capture_trigger(cap), .o_conversion_start(st));
    acc_analog_model model (.i_clock, .i_pos_pin(pos), .i_neg_pin(8'h64),
        .i_channels(chans), .i_bandgap(bg), .i_neg_mux(from_mux),
        .i_chan(o_negative_channel), .i_off(off), .o_raw(raw));
    // ========
    // Bus tasks and result monitor
    task automatic tick(int k);
        repeat (k) @(negedge i_clock);
    endtask
    task automatic wr(logic io, logic [7:0] a, logic [7:0] d);
        tick(1);
        {i_io_space, i_addr, i_wdata, i_wr} = {io, a, d, 1'b1};
        tick(1);
        i_wr = 1'b0;
    endtask
    task automatic rd(logic io, logic [7:0] a, logic [7:0] x);
        tick(1);
        {i_io_space, i_addr, i_rd} = {io, a, 1'b1};
        exp_q.push_back(x);
        tick(1);
        i_rd = 1'b0;
    endtask
    task automatic starts(output int c);
        c = 0;
        repeat (6) @(posedge i_clock) #1 c += (st !== 1'b0);
        tick(1);
    endtask
    task automatic summarize();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge i_clock) rd_seen <= i_rd;
    always @(negedge i_clock) if (rd_seen) `CHK(o_rdata, exp_q.pop_front())
    initial
    begin
        repeat (20000) @(posedge i_clock);
        n_fail++;
        summarize();
    end
    // ========
    // Main sequence
    initial
    begin
        chans = {$random(seed), $random(seed)};
        pos = 8'($random(seed));
        tick(4);
        i_srst = 1'b0;
        rd(1'b0, ACC_CTRLB_ADDR, ACC_CTRLB_RESET);
        rd(1'b1, ACC_CSR_IO_ADDR, {2'b00, pos > 8'h64, 5'h00});
        wr(1'b0, ACC_CTRLB_ADDR, 8'hFF);
        rd(1'b0, ACC_CTRLB_ADDR, ACC_CTRLB_MASK);
        wr(1'b0, ACC_CSR_ADDR, 8'h04);
        // Converter power-reduce taken as clear here
        for (int ch = 0; ch < 8; ch++)
        begin
            chsel = ch[2:0];
            tick(6);
            `CHK({from_mux, o_negative_channel}, {1'b1, ch[2:0]})
            `CHK(cap, pos > chans[ch*8 +: 8])
        end
        conv_en = 1'b1;
        pos = 8'h00;
        tick(6);
        `CHK({from_mux, o_negative_channel}, 4'h0)
        $display("end mux test");
        for (int m = 0; m < 4; m++)
            for (int e = 0; e < 2; e++)
            begin
                logic [7:0] a;
                a = e ? ACC_CSR_IO_ADDR : ACC_CSR_ADDR;
                gie = e[0];
                wr(e[0], a, {6'h06, m[1:0]});
                pos = e ? 8'h00 : 8'hC8;
                tick(6);
                f = m == 0 || (m == 3 && e == 0) || (m == 2 && e == 1);
                `CHK(irq, f & e[0])
                wr(e[0], a, {6'h02, m[1:0]});
                rd(e[0], a, {2'b00, !e[0], f, 2'b10, m[1:0]});
                vec = 1'b1;
                tick(1);
                vec = 1'b0;
                rd(e[0], a, {2'b00, !e[0], 1'b0, 2'b10, m[1:0]});
            end
        $display("end flag test");
        wr(1'b0, ACC_CSR_ADDR, 8'h14);
        wr(1'b0, ACC_CSR_ADDR, 8'h94);
        wr(1'b0, ACC_CSR_ADDR, 8'h9C);
        tick(10);
        `CHK({off, irq, cap}, 3'b100)
        wr(1'b0, ACC_CSR_ADDR, 8'h94);
        wr(1'b0, ACC_CSR_ADDR, 8'h44);
        tick(6);
        `CHK({bg, cap}, 2'b11)
        $display("end power test");
        for (int a = 0; a < 2; a++)
            for (int c = 0; c < 8; c++)
                if (c != 1)
                begin
                    auto_en = a[0];
                    flags = 8'h00;
                    wr(1'b0, ACC_CTRLB_ADDR, c[7:0]);
                    flags = 8'($random(seed)) & ~(8'h01 << c);
                    tick(2);
                    flags[c] = 1'b1;
                    starts(n);
                    `CHK(n, (a == 1 && c != 0) ? 1 : 0)
                end
        flags = 8'h08;
        wr(1'b0, ACC_CTRLB_ADDR, 8'h02);
        tick(3);
        wr(1'b0, ACC_CTRLB_ADDR, 8'h03);
        starts(n);
        `CHK(n, 1)
        flags = 8'hFF;
        wr(1'b0, ACC_CTRLB_ADDR, 8'h00);
        starts(n);
        `CHK(n, 0)
        wr(1'b0, ACC_CSR_ADDR, 8'h13);
        tick(4);
        wr(1'b0, ACC_CTRLB_ADDR, 8'h01);
        pos = 8'hC8;
        starts(n);
        `CHK(n, 1)
        $display("end trigger test");
        summarize();
    end
endmodule // tb_acc_comparator_control
